//--- design/crs_regs.svh
// Offsets, field positions, reset values and timing of the rate block
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CRS_OFS_RATE_CMD   8'h00
`define CRS_OFS_CTRL       8'h04
`define CRS_OFS_STATUS     8'h08
`define CRS_OFS_MIX_BASE   8'h0C
`define CRS_OFS_MIX_LAST   8'h28

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define CRS_CMD_RATE       8'h40
`define CRS_CMD_LSB        8
`define CRS_CTRL_PWR_BIT   0
`define CRS_STAT_LR_BIT    8
`define CRS_STAT_REJ_BIT   9
`define CRS_STAT_CODE_LSB  16
`define CRS_MIX_MUTE_BIT   7
`define CRS_RATE_LAST      8'hEB

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CRS_RST_CODE       8'h00
`define CRS_RST_CTRL       1'h0
`define CRS_RST_MIX        8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CRS_CLK_HZ         10000000
`define CRS_MCLK_PER_FS    256
`define CRS_ACC_MOD        (35'(`CRS_CLK_HZ) * 35'd1000)

`endif

//--- design/crs_pkg.sv
// Types shared by the codec rate and sample port block
`default_nettype none
package crs_pkg;
  // Index of each mixer setting slot
  typedef enum logic [2:0] {
    CRS_MIX_DAC    = 3'b000,
    CRS_MIX_LINE   = 3'b001,
    CRS_MIX_CD     = 3'b010,
    CRS_MIX_AUX    = 3'b011,
    CRS_MIX_SYNTH  = 3'b100,
    CRS_MIX_MIC    = 3'b101,
    CRS_MIX_REC    = 3'b110,
    CRS_MIX_MASTER = 3'b111
  } crs_mix_t;
  typedef logic [7:0] crs_byte_t;
endpackage
`default_nettype wire

//--- design/crs_top.sv
// Rate synthesizer, stereo sample port and mixer level control
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`default_nettype none
`include "crs_regs.svh"
// Summary of operation
// RL1: 236 master-clock rates from 8-bit code
// RL2: Rates derived from crystal reference table
// RL3: Master clock runs at 256 times fs
// RL4: Powered down: master clock held, no toggling
// RL5: Rate code loaded by command 40h
// RL6: Fixed code-to-frequency table, 0 through 235
// RL7: Critical rates within 0.15 percent
// RL8: Sampling rates span 5 to 48 kHz
// RL9: Modulators oversample 128 times
// RL10: Playback interpolation raises rate eight times
// RL11: Channel strobe period equals sample period
// RL12: Partner presents one left, one right word
// RL13: Strobe low left, high right
// RL14: Left then right form one instant
// RL15: ADC words multiplexed with same phase convention
// RL16: Each mixer source has gain and mute
// RL17: DAC mixer gain 32 steps of 1.5dB
// RL18: Line, CD, aux, synth: 16 steps 3dB
// RL19: Selectable 20dB microphone boost
// RL20: Record gain 16 steps of 1.5dB
// RL21: Master attenuation in 3dB steps to 93dB
// RL22: New levels apply only at zero crossing
// RL23: Codes above 235 ignored, old rate kept
module crs_top
  import crs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Sample port
  input  wire logic [15:0] dac_data,
  input  wire logic [15:0] adc_left_in,
  input  wire logic [15:0] adc_right_in,
  input  wire logic        adc_capture,
  output logic             lr_select,
  output logic [15:0]      adc_data,
  output logic [15:0]      dac_left,
  output logic [15:0]      dac_right,
  output logic             dac_pair_strobe,
  // Synthesizer
  output logic [7:0]       mclk_phase,
  output logic             mclk_active,
  output logic             mod_strobe,
  output logic             interp_strobe,
  // Mixer zero-crossing detectors, one per slot, asynchronous
  input  wire logic [7:0]  zero_cross,
  output logic [4:0]       dac_gain,
  output logic             dac_mute,
  output logic [3:0]       line_gain,
  output logic             line_mute,
  output logic [3:0]       cd_gain,
  output logic             cd_mute,
  output logic [3:0]       aux_gain,
  output logic             aux_mute,
  output logic [3:0]       synth_gain,
  output logic             synth_mute,
  output logic             mic_boost,
  output logic             mic_mute,
  output logic [3:0]       record_gain,
  output logic [4:0]       master_atten
);

  // ----------------------------------------
  // Rate table, output sample frequency in millihertz per code
  // ----------------------------------------
  // Covers 3.9 kHz to 48 kHz, so 5 to 48 kHz is reachable  RL8
  localparam int unsigned RATE_TABLE [0:235] = '{ // RL6
    3909064, 3924890, 3938710, 3947978, 3951554, 3957289, 3994978,
    4030968, 4033391, 4047543, 4067614, 4084752, 4092416, 4112477,
    4131170, 4142940, 4164977, 4178655, 4209761, 4221108, 4237097,
    4255520, 4276976, 4302284, 4302284, 4327892, 4350087, 4369507,
    4386642, 4415502, 4433451, 4448952, 4462475, 4488185, 4500090,
    4523725, 4544287, 4565689, 4584401, 4601810, 4605974, 4609590,
    4660807,
    4713176, 4716962, 4739804, 4759973, 4783460, 4806457, 4833430,
    4847240, 4877589, 4906113, 4934972, 4955795, 4971528, 4993722,
    5019331, 5049208, 5084517, 5115520, 5126888, 5151419, 5178675,
    5202762, 5243408, 5268739, 5290646, 5326637, 5346220, 5377855,
    5412550, 5437608, 5456555, 5493094, 5514194, 5519377, 5523920,
    5592969, 5668549, 5680359, 5720082, 5746201, 5785830, 5804024,
    5843400,
    5887335, 5915640, 5949967, 5992466, 6023197, 6059049, 6101420,
    6138624, 6168715, 6214410, 6260786, 6292090, 6331663, 6377947,
    6408610, 6453425, 6491839, 6544963, 6579963, 6615339, 6670513,
    6711562, 6750135, 6802259, 6848533, 6895441, 6935281, 6991211,
    7049961, 7089679, 7139960, 7190960, 7250145, 7295177, 7359169,
    7402459, 7457292, 7512943, 7573812, 7626775, 7690332, 7752630,
    7813706,
    7877421, 7935969, 7989955, 8066782, 8129315, 8196592, 8262340,
    8329953, 8389453, 8474195, 8544813, 8636202, 8691776, 8773284,
    8849634, 8924950, 9005628, 9088574, 9175964, 9219179, 9321614,
    9433923, 9519947, 9599872, 9710015, 9805854, 9904215, 10025133,
    10098416, 10209387, 10302837, 10418275, 10532214, 10634518,
    10755709, 10875217, 10986188, 11028389, 11263617, 11360718,
    11485561, 11616166, 11774671,
    11910952, 12046394, 12189804, 12356559, 12494931, 12663325,
    12817220, 12983677, 13159926, 13332077, 13511104, 13697066,
    13866865, 14099921, 14286387, 14487810, 14703165, 14914583,
    15147624, 15380664, 15627413, 15871938, 16018697, 16379408,
    16665917, 16948390, 17244987, 17537275, 17839642, 18177148,
    18511939, 18905810, 19225830, 19617129, 20034515, 20418775,
    20836550, 21286672, 21750434, 22049203, 22721435, 23238391,
    23821904,
    24394863, 24989860, 25634440, 26303566, 27446976, 27703490,
    28566238, 29417563, 30295247, 31254825, 32007953, 33080364,
    34502080, 35691971, 37053418, 38003505, 40005262, 41693039,
    44098407, 45495044, 48006315
  };

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Level bits that each mixer slot really holds
  function automatic crs_byte_t mix_mask(input logic [2:0] idx);
    case (idx)
      CRS_MIX_DAC:    mix_mask = 8'h9F; // RL17
      CRS_MIX_MIC:    mix_mask = 8'h81; // RL19
      CRS_MIX_REC:    mix_mask = 8'h0F; // RL20
      CRS_MIX_MASTER: mix_mask = 8'h1F; // RL21
      default:        mix_mask = 8'h8F; // RL18
    endcase
  endfunction

  // Table lookup widened to accumulator step
  function automatic logic [34:0] rate_step(input crs_byte_t code);
    int unsigned f;
    f = RATE_TABLE[code];
    rate_step = 35'(f) * 35'(`CRS_MCLK_PER_FS); // RL3
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic             dp_write;      // Data phase of a write pending
  logic [7:0]       dp_addr;       // Byte address held for data phase
  crs_byte_t        rate_code;     // Current selected rate
  logic             power_up;      // Synthesizer power
  logic             rate_rej;      // Last rate command was refused
  crs_byte_t        mix_req [0:7]; // Levels written by software
  crs_byte_t        mix_now [0:7]; // Levels applied to the mixer
  logic [34:0]      acc;           // Fractional phase accumulator
  logic [31:0]      rd_value;      // Read data for the address phase
  logic [2:0]       mix_idx;       // Slot hit by the held address
  logic [2:0]       rd_idx;        // Slot hit by the new address
  logic             addr_ok;       // Address phase taken

  assign addr_ok = hsel & hready & htrans[1];
  assign mix_idx = 3'((dp_addr - `CRS_OFS_MIX_BASE) >> 2);
  assign rd_idx  = 3'((haddr[7:0] - `CRS_OFS_MIX_BASE) >> 2);

  wire hi_zero   = (haddr[31:8] == 24'h000000);
  wire in_mix_wr = (dp_addr >= `CRS_OFS_MIX_BASE) &&
                   (dp_addr <= `CRS_OFS_MIX_LAST);
  wire in_mix_rd = (haddr[7:0] >= `CRS_OFS_MIX_BASE) &&
                   (haddr[7:0] <= `CRS_OFS_MIX_LAST) && hi_zero;
  wire wr_cmd    = dp_write && (dp_addr == `CRS_OFS_RATE_CMD);
  wire cmd_rate  = wr_cmd &&
                   (hwdata[15:`CRS_CMD_LSB] == `CRS_CMD_RATE); // RL5
  wire code_ok   = (hwdata[7:0] <= `CRS_RATE_LAST); // RL23

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (hi_zero && haddr[7:0] == `CRS_OFS_RATE_CMD) begin
      rd_value[7:0] = rate_code;
    end else if (hi_zero && haddr[7:0] == `CRS_OFS_CTRL) begin
      rd_value[`CRS_CTRL_PWR_BIT] = power_up;
    end else if (hi_zero && haddr[7:0] == `CRS_OFS_STATUS) begin
      rd_value[7:0] = mclk_phase;
      rd_value[`CRS_STAT_LR_BIT] = lr_select;
      rd_value[`CRS_STAT_REJ_BIT] = rate_rej;
      rd_value[`CRS_STAT_CODE_LSB +: 8] = rate_code;
    end else if (in_mix_rd) begin
      rd_value[7:0] = mix_req[rd_idx];
    end
  end

  // Address phase capture and zero-wait answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_write  <= addr_ok & hwrite & hi_zero;
      dp_addr   <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

  // Control registers; a refused code leaves the old rate in place
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_code <= `CRS_RST_CODE;
      power_up  <= `CRS_RST_CTRL;
      rate_rej  <= 1'b0;
    end else begin
      if (cmd_rate && code_ok) begin
        rate_code <= hwdata[7:0]; // RL1
      end
      if (cmd_rate) begin
        rate_rej <= ~code_ok; // RL23
      end
      if (dp_write && dp_addr == `CRS_OFS_CTRL) begin
        power_up <= hwdata[`CRS_CTRL_PWR_BIT];
      end
    end
  end

  // ----------------------------------------
  // Rate synthesizer
  // ----------------------------------------
  // Up to two master cycles fit in one bus clock at 48 kHz, so the
  // master clock is carried as a cycle count rather than a wire.
  logic [35:0] acc_sum;  // Accumulator plus step
  logic [1:0]  mclk_adv; // Master cycles completed this clock
  logic [34:0] next_acc;
  logic [7:0]  next_phase;
  logic        next_lr;

  wire [35:0] mod1 = 36'(`CRS_ACC_MOD);
  wire [35:0] mod2 = 36'(`CRS_ACC_MOD) << 1;

  // Exact millihertz accumulation keeps every rate on its table value
  always_comb begin
    acc_sum  = 36'(acc) + 36'(rate_step(rate_code)); // RL2 RL7
    next_acc = acc;
    mclk_adv = 2'd0;
    if (acc_sum >= mod2) begin
      next_acc = 35'(acc_sum - mod2);
      mclk_adv = 2'd2;
    end else if (acc_sum >= mod1) begin
      next_acc = 35'(acc_sum - mod1);
      mclk_adv = 2'd1;
    end else begin
      next_acc = 35'(acc_sum);
    end
  end

  assign next_phase = power_up ? mclk_phase + 8'(mclk_adv) : 8'h00; // RL4
  assign next_lr    = next_phase[7]; // RL11 RL13

  // Phase, strobe and oversampling ticks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc           <= 35'h0;
      mclk_phase    <= 8'h00;
      mclk_active   <= 1'b0;
      lr_select     <= 1'b0;
      mod_strobe    <= 1'b0;
      interp_strobe <= 1'b0;
    end else begin
      acc           <= power_up ? next_acc : 35'h0; // RL4
      mclk_phase    <= next_phase; // RL3
      mclk_active   <= power_up;
      lr_select     <= next_lr;
      mod_strobe    <= next_phase[7:1] != mclk_phase[7:1]; // RL9
      interp_strobe <= next_phase[7:5] != mclk_phase[7:5]; // RL10
    end
  end

  // ----------------------------------------
  // Sample port
  // ----------------------------------------
  logic [15:0] left_hold;  // Last word seen while strobe low
  logic [15:0] adc_l;      // Captured ADC left
  logic [15:0] adc_r;      // Captured ADC right

  wire pair_done = lr_select & ~next_lr; // RL14

  // Pair one left with the following right; the last word of each half
  // counts, so the right word is taken off the bus at the closing edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_hold       <= 16'h0000;
      dac_left        <= 16'h0000;
      dac_right       <= 16'h0000;
      dac_pair_strobe <= 1'b0;
    end else begin
      if (!lr_select) begin
        left_hold <= dac_data; // RL13 RL12
      end
      dac_pair_strobe <= pair_done;
      if (pair_done) begin
        dac_left  <= left_hold; // RL14
        dac_right <= dac_data; // RL13
      end
    end
  end

  // ADC results follow the same low-left, high-right phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_l    <= 16'h0000;
      adc_r    <= 16'h0000;
      adc_data <= 16'h0000;
    end else begin
      if (adc_capture) begin
        adc_l <= adc_left_in;
        adc_r <= adc_right_in;
      end
      adc_data <= next_lr ? adc_r : adc_l; // RL15
    end
  end

  // ----------------------------------------
  // Mixer levels
  // ----------------------------------------
  logic [7:0] zc_meta; // First synchroniser stage
  logic [7:0] zc_sync; // Safe zero-crossing levels

  // Detectors are analog, so two flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zc_meta <= 8'h00;
      zc_sync <= 8'h00;
    end else begin
      zc_meta <= zero_cross;
      zc_sync <= zc_meta;
    end
  end

  // Requested level moves to the mixer only on a crossing, which
  // avoids zipper clicks at the cost of a wait on silent inputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        mix_req[i] <= `CRS_RST_MIX;
        mix_now[i] <= `CRS_RST_MIX;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (zc_sync[i]) begin
          mix_now[i] <= mix_req[i]; // RL22
        end
      end
      if (dp_write && in_mix_wr) begin
        mix_req[mix_idx] <= hwdata[7:0] & mix_mask(mix_idx); // RL16
      end
    end
  end

  // Applied levels out to the analog mixer
  assign dac_gain     = mix_now[CRS_MIX_DAC][4:0]; // RL17
  assign dac_mute     = mix_now[CRS_MIX_DAC][`CRS_MIX_MUTE_BIT];
  assign line_gain    = mix_now[CRS_MIX_LINE][3:0]; // RL18
  assign line_mute    = mix_now[CRS_MIX_LINE][`CRS_MIX_MUTE_BIT];
  assign cd_gain      = mix_now[CRS_MIX_CD][3:0];
  assign cd_mute      = mix_now[CRS_MIX_CD][`CRS_MIX_MUTE_BIT];
  assign aux_gain     = mix_now[CRS_MIX_AUX][3:0];
  assign aux_mute     = mix_now[CRS_MIX_AUX][`CRS_MIX_MUTE_BIT];
  assign synth_gain   = mix_now[CRS_MIX_SYNTH][3:0];
  assign synth_mute   = mix_now[CRS_MIX_SYNTH][`CRS_MIX_MUTE_BIT];
  assign mic_boost    = mix_now[CRS_MIX_MIC][0]; // RL19
  assign mic_mute     = mix_now[CRS_MIX_MIC][`CRS_MIX_MUTE_BIT];
  assign record_gain  = mix_now[CRS_MIX_REC][3:0]; // RL20
  assign master_atten = mix_now[CRS_MIX_MASTER][4:0]; // RL21

  wire unused_ok = &{1'b0, hsize, haddr[1:0], hwdata[31:16]};

endmodule
`default_nettype wire

//--- test/crs_monitor.sv
// Port-level assertions for the codec rate and sample port block
`default_nettype none
module crs_monitor (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  mclk_phase,
  input wire logic        mclk_active,
  input wire logic        mod_strobe,
  input wire logic        interp_strobe,
  input wire logic        lr_select,
  input wire logic        dac_pair_strobe,
  input wire logic        adc_capture,
  input wire logic [15:0] adc_left_in,
  input wire logic [15:0] adc_right_in,
  input wire logic [15:0] adc_data,
  input wire logic [7:0]  zero_cross,
  input wire logic [4:0]  dac_gain,
  input wire logic [4:0]  master_atten
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Shadow of the converter words
  // ----------------------------------------
  logic [15:0] cap_l;  // Left word at last capture
  logic [15:0] cap_r;  // Right word at last capture
  // Latched on the pulse only; the lines are scrambled after it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_l <= 16'h0000;
      cap_r <= 16'h0000;
    end else if (adc_capture) begin
      cap_l <= adc_left_in;
      cap_r <= adc_right_in;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Two cycles off, so the clear has landed
  sequence s_off2;
    !mclk_active [*2];
  endsequence
  // Two cycles running, so $past is from a running cycle
  sequence s_on2;
    mclk_active [*2];
  endsequence
  a_bus_ready_okay: assert property ($past(nrst) |-> hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_mclk_held_off: assert property (s_off2 |-> mclk_phase == 8'h00
    && !mod_strobe && !interp_strobe)
    else $error("master clock moves while powered down");
  a_phase_step_max: assert property (s_on2 |->
    8'(mclk_phase - $past(mclk_phase)) <= 8'h02)
    else $error("master clock phase jumped");
  a_lr_from_phase: assert property (s_on2 |->
    lr_select == mclk_phase[7])
    else $error("channel strobe not tied to phase");
  a_pair_on_fall: assert property (
    mclk_active && $fell(lr_select) |-> dac_pair_strobe)
    else $error("no pair strobe at channel fall");
  a_pair_one_cycle: assert property (
    dac_pair_strobe |-> $fell(lr_select) ##1 !dac_pair_strobe)
    else $error("pair strobe misplaced or too long");
  a_adc_left_half: assert property ($fell(lr_select) |-> adc_data == cap_l)
    else $error("left word not on converter bus");
  a_adc_right_half: assert property ($rose(lr_select) |-> adc_data == cap_r)
    else $error("right word not on converter bus");
  a_dac_level_zc: assert property ($changed(dac_gain) |->
    $past(zero_cross[0], 2) || $past(zero_cross[0], 3))
    else $error("playback level changed without crossing");
  a_master_level_zc: assert property ($changed(master_atten) |->
    $past(zero_cross[7], 2) || $past(zero_cross[7], 3))
    else $error("master level changed without crossing");
endmodule
bind crs_top crs_monitor mon_u (.clk, .nrst, .hreadyout, .hresp,
  .mclk_phase, .mclk_active, .mod_strobe, .interp_strobe, .lr_select,
  .dac_pair_strobe, .adc_capture, .adc_left_in, .adc_right_in, .adc_data,
  .zero_cross, .dac_gain, .master_atten);
`default_nettype wire

//--- test/crs_audio_proc.sv
// Behavioural audio processor feeding playback and converter words to the sample port
`default_nettype none
module crs_audio_proc (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        lr_select,
  input  wire logic        dac_pair_strobe,
  output logic [15:0]      dac_data,
  output logic [15:0]      adc_left_in,
  output logic [15:0]      adc_right_in,
  output logic             adc_capture,
  output logic [7:0]       sample_idx
);
  timeunit 1ns;
  timeprecision 1ns;
  // Word marks its half and sample; low half left, high half right
  assign dac_data = lr_select ? {8'hB0, sample_idx}
                              : {8'hA0, sample_idx};
  // One new pair per strobe cycle; capture pulse follows the pair strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_idx   <= 8'h00;
      adc_capture  <= 1'b0;
      adc_left_in  <= 16'h0000;
      adc_right_in <= 16'h0000;
    end else begin
      adc_capture <= dac_pair_strobe;
      if (dac_pair_strobe) begin
        sample_idx   <= sample_idx + 8'h01;
        adc_left_in  <= {8'hC0, sample_idx};
        adc_right_in <= {8'hD0, sample_idx};
      end else if (adc_capture) begin
        // Taken: scramble so a late sample shows up
        adc_left_in  <= ~adc_left_in;
        adc_right_in <= ~adc_right_in;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/crs_top_tb.sv
// Self-checking bench for the codec rate and sample port block
`default_nettype none
`include "crs_regs.svh"
module crs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIM = 3000;  // Bound on every wait
  localparam logic [31:0] A_RATE = 32'(`CRS_OFS_RATE_CMD);
  localparam logic [31:0] A_CTRL = 32'(`CRS_OFS_CTRL);
  localparam logic [31:0] A_STAT = 32'(`CRS_OFS_STATUS);
  localparam logic [31:0] A_MIX  = 32'(`CRS_OFS_MIX_BASE);
  localparam logic [7:0]  CODE [4] = '{8'h00, 8'hA6, 8'hD3, 8'hEB};
  localparam int PLO [4] = '{2558, 906, 453, 208};  // Shortest sample period
  localparam logic [7:0] RMASK [8] = '{8'h9F, 8'h8F, 8'h8F, 8'h8F, 8'h8F,
                                       8'h81, 8'h0F, 8'h1F};
  localparam logic [36:0] FMASK [8] = '{37'h3F << 31, 37'h1F << 26,
    37'h1F << 21, 37'h1F << 16, 37'h1F << 11, 37'h3 << 9, 37'hF << 5, 37'h1F};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;  // Whole words only
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  zero_cross = 8'h00;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, adc_capture, lr_select, dac_pair_strobe;
  logic        mclk_active, mod_strobe, interp_strobe;
  logic [15:0] dac_data, adc_left_in, adc_right_in, adc_data;
  logic [15:0] dac_left, dac_right;
  logic [7:0]  mclk_phase, sample_idx;
  logic [4:0]  dac_gain, master_atten;
  logic [3:0]  line_gain, cd_gain, aux_gain, synth_gain, record_gain;
  logic        dac_mute, line_mute, cd_mute, aux_mute, synth_mute;
  logic        mic_boost, mic_mute;
  logic [36:0] mix_outs;  // All applied levels, slot 0 at the top
  int          miscompares = 0;
  int          samples_checked = 0;
  assign mix_outs = {dac_gain, dac_mute, line_gain, line_mute, cd_gain,
    cd_mute, aux_gain, aux_mute, synth_gain, synth_mute, mic_boost, mic_mute,
    record_gain, master_atten};
  always #50 clk = ~clk;
  crs_top dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dac_data,
    .adc_left_in, .adc_right_in, .adc_capture, .lr_select, .adc_data,
    .dac_left, .dac_right, .dac_pair_strobe, .mclk_phase, .mclk_active,
    .mod_strobe, .interp_strobe, .zero_cross, .dac_gain, .dac_mute,
    .line_gain, .line_mute, .cd_gain, .cd_mute, .aux_gain, .aux_mute,
    .synth_gain, .synth_mute, .mic_boost, .mic_mute, .record_gain,
    .master_atten);
  crs_audio_proc prt_u (.clk, .nrst, .lr_select, .dac_pair_strobe,
    .dac_data, .adc_left_in, .adc_right_in, .adc_capture, .sample_idx);
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A used-up bound is a failure and ends the run
  task automatic guard(input int n);
    if (n >= LIM) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // ----------------------------------------
  // Bus master, entered just after a rising edge
  // ----------------------------------------
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < LIM);
    guard(n);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;  // Address phase held until ready
    haddr  <= a;
    hwrite <= w;
    edge_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    rd = hrdata;  // Taken at the closing edge
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk(v & m, exp);
  endtask
  // ----------------------------------------
  // Sample timing, seen at mid-cycle
  // ----------------------------------------
  task automatic to_pair(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dac_pair_strobe !== 1'b1 && n < LIM);
    guard(n);
  endtask
  // One full sample: length, strobe counts and the pair just closed
  task automatic measure(input int lo);
    int n;
    int mps;
    int ips;
    to_pair(n);
    mps = 0;
    ips = 0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (mod_strobe === 1'b1) mps++;
      if (interp_strobe === 1'b1) ips++;
    end while (dac_pair_strobe !== 1'b1 && n < LIM);
    guard(n);
    chk(n >= lo && n <= lo + 1, 1'b1);
    chk(mps, 128);
    chk(ips, 8);
    chk({dac_left, dac_right}, {8'hA0, sample_idx, 8'hB0, sample_idx});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [36:0] exp_mix;
    int n;
    exp_mix = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({mclk_active, mclk_phase}, 9'h000);
    repeat (2) @(posedge clk);
    rdc(A_RATE, 32'hFF, 32'h0);
    rdc(A_CTRL, 32'h1, 32'h0);
    wr(A_RATE, {16'h0, `CRS_CMD_RATE, 8'hEB});
    rdc(A_RATE, 32'hFF, 32'hEB);
    rdc(A_STAT, 32'hFF_0200, 32'hEB_0000);
    wr(A_RATE, {16'h0, `CRS_CMD_RATE, 8'hEC});
    rdc(A_RATE, 32'hFF, 32'hEB);
    rdc(A_STAT, 32'h200, 32'h200);
    wr(A_RATE, {16'h0, 8'h41, 8'h05});
    rdc(A_RATE, 32'hFF, 32'hEB);
    rdc(32'h100, 32'hFFFF_FFFF, 32'h0);
    wr(A_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(A_RATE, {16'h0, `CRS_CMD_RATE, CODE[i]});
      measure(PLO[i]);
      @(posedge clk);
    end
    wr(A_CTRL, 32'h0);
    repeat (3) @(negedge clk);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if ({mclk_phase, mod_strobe, lr_select, dac_pair_strobe} !== 11'h0) n++;
    end
    chk(n, 0);
    @(posedge clk);
    // Each slot: request, hold without crossing, then apply on crossing
    for (int i = 0; i < 8; i++) begin
      wr(A_MIX + 32'(4 * i), 32'hFF);
      rdc(A_MIX + 32'(4 * i), 32'hFF, 32'(RMASK[i]));
      @(negedge clk);
      chk(mix_outs, exp_mix);
      @(posedge clk);
      zero_cross <= 8'h01 << i;
      repeat (4) @(posedge clk);
      zero_cross <= 8'h00;
      exp_mix = exp_mix | FMASK[i];
      @(negedge clk);
      chk(mix_outs, exp_mix);
      @(posedge clk);
    end
    for (int i = 0; i < 8; i++) wr(A_MIX + 32'(4 * i), 32'h0);
    @(negedge clk);
    chk(mix_outs, exp_mix);
    @(posedge clk);
    zero_cross <= 8'hFF;
    repeat (4) @(posedge clk);
    zero_cross <= 8'h00;
    @(negedge clk);
    chk(mix_outs, 37'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
